// ==== rtl/flyback_protection_defs.vh ====
`ifndef FLYBACK_PROTECTION_DEFS_VH
`define FLYBACK_PROTECTION_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS        10
`define MAX_ON_TIME_US       40
`define MAX_ON_CYCLES        ((`MAX_ON_TIME_US * 1000) / `CLK_PERIOD_NS)
`define LEB_TIME_NS          300
`define LEB_CYCLES           ((`LEB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESTART_TIME_US      100
`define RESTART_CYCLES       ((`RESTART_TIME_US * 1000) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Overvoltage counter
// ----------------------------------------------------------------
`define OV_TRIP_COUNT        8
`define OV_UP_STEP           1
`define OV_DOWN_STEP         2

// ----------------------------------------------------------------
// Peak limit compensation
// ----------------------------------------------------------------
`define LIMIT_WIDTH          8
`define LIMIT_RESET          8'hff

`endif

// ==== rtl/ov_event_counter.v ====
`timescale 1ns/1ns
`default_nettype none
`include "flyback_protection_defs.vh"

module ov_event_counter #(
  parameter integer TRIP_COUNT = `OV_TRIP_COUNT
) (
  input  wire clk_in,
  input  wire resetn_in,
  input  wire cycle_end_in,
  input  wire ov_seen_in,
  output reg  trip_out
);

  reg [4:0] count_r;
  reg [4:0] count_nxt;
  localparam [4:0] TRIP = TRIP_COUNT[4:0];

  always @*
  begin
    count_nxt = count_r;
    if (cycle_end_in)
    begin
      if (ov_seen_in)
      begin
        if (count_r < TRIP)
          count_nxt = count_r + 5'h01;
      end
      else
      begin
        if (count_r >= 5'h02)
          count_nxt = count_r - 5'h02;
        else
          count_nxt = 5'h00;
      end
    end
  end

  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      count_r <= 5'h00;
    else
      count_r <= count_nxt;
  end

  // Look-ahead on the closing edge, so a tripping cycle never switches on
  always @*
  begin
    trip_out = (count_nxt >= TRIP);
  end

endmodule // ov_event_counter

`default_nettype wire

// ==== rtl/flyback_protection_logic.v ====
`timescale 1ns/1ns
`default_nettype none
`include "flyback_protection_defs.vh"

module flyback_protection_logic #(
  parameter integer MAX_ON_CYCLES  = `MAX_ON_CYCLES,
  parameter integer LEB_CYCLES     = `LEB_CYCLES,
  parameter integer RESTART_CYCLES = `RESTART_CYCLES,
  parameter integer LIMIT_WIDTH    = `LIMIT_WIDTH
) (
  input  wire                   clk_in,
  input  wire                   resetn_in,
  input  wire                   cycle_start_in,
  input  wire                   secondary_stroke_in,
  input  wire                   aux_winding_sense_in,
  input  wire                   primary_current_sense_in,
  input  wire [LIMIT_WIDTH-1:0] overpower_compensation_in,
  input  wire                   latch_reset_in,
  output reg                    flyback_gate_drive_out,
  output reg  [LIMIT_WIDTH-1:0] overcurrent_limit_out,
  output reg                    ov_latched_out,
  output reg                    safe_restart_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE    = 2'h0;
  localparam [1:0] ST_ON      = 2'h1;
  localparam [1:0] ST_OFF     = 2'h2;
  localparam [1:0] ST_RESTART = 2'h3;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [31:0] on_cnt_r;
  reg  [31:0] restart_cnt_r;
  reg         ov_seen_r;
  reg         start_prev_r;
  reg         gate_nxt;
  wire        start_edge;
  wire        cycle_close;
  wire        ov_trip;
  wire        leb_done;
  wire        on_expired;
  wire        oc_hit;

  assign leb_done   = (on_cnt_r >= LEB_CYCLES);
  assign on_expired = (on_cnt_r >= MAX_ON_CYCLES);
  assign oc_hit     = primary_current_sense_in && leb_done;

  // ----------------------------------------------------------------
  // Cycle start
  // ----------------------------------------------------------------
  // A start level held high must not count as many switching cycles
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      start_prev_r <= 1'b0;
    else
      start_prev_r <= cycle_start_in;
  end

  assign start_edge  = cycle_start_in && !start_prev_r;
  assign cycle_close = start_edge && (state_r == ST_OFF);

  // ----------------------------------------------------------------
  // Overvoltage filter
  // ----------------------------------------------------------------
  // One verdict per switching cycle that ends in ST_OFF, taken when the next cycle starts
  ov_event_counter #(
    .TRIP_COUNT (`OV_TRIP_COUNT)
  ) u_ov_count (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .cycle_end_in (cycle_close),
    .ov_seen_in   (ov_seen_r),
    .trip_out     (ov_trip)
  );

  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      ov_seen_r <= 1'b0;
    else if (cycle_close)
      ov_seen_r <= 1'b0;
    else if (secondary_stroke_in && aux_winding_sense_in)
      ov_seen_r <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Gate sequencing
  // ----------------------------------------------------------------
  always @*
  begin
    state_nxt = state_r;
    gate_nxt  = 1'b0;
    case (state_r)
      ST_IDLE, ST_OFF:
      begin
        if (start_edge && !ov_latched_out && !ov_trip)
        begin
          state_nxt = ST_ON;
          gate_nxt  = 1'b1;
        end
      end
      ST_ON:
      begin
        gate_nxt = 1'b1;
        if (on_expired)
        begin
          state_nxt = ST_RESTART;
          gate_nxt  = 1'b0;
        end
        else if (oc_hit || ov_trip || ov_latched_out)
        begin
          state_nxt = ST_OFF;
          gate_nxt  = 1'b0;
        end
      end
      ST_RESTART:
      begin
        if (restart_cnt_r >= RESTART_CYCLES)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_r                <= ST_IDLE;
      flyback_gate_drive_out <= 1'b0;
      safe_restart_out       <= 1'b0;
    end
    else
    begin
      state_r                <= state_nxt;
      flyback_gate_drive_out <= gate_nxt;
      safe_restart_out       <= (state_nxt == ST_RESTART);
    end
  end

  // ----------------------------------------------------------------
  // On-time and blanking timer
  // ----------------------------------------------------------------
  // Restarts from zero every on-period so blanking always covers turn-on
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      on_cnt_r <= 32'h0;
    // timers run only while gate is on
    else if (gate_nxt && (state_r == ST_ON))
      on_cnt_r <= on_cnt_r + 32'h1;
    else
      on_cnt_r <= 32'h0;
  end

  // ----------------------------------------------------------------
  // Safe restart timer
  // ----------------------------------------------------------------
  // Counts from zero at entry, so the hold-off lasts RESTART_CYCLES plus one clock
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      restart_cnt_r <= 32'h0;
    // hold off for the restart time
    else if (state_r == ST_RESTART)
      restart_cnt_r <= restart_cnt_r + 32'h1;
    else
      restart_cnt_r <= 32'h0;
  end

  // ----------------------------------------------------------------
  // Protection latch
  // ----------------------------------------------------------------
  // Trip wins over a simultaneous reset so a live fault is never lost
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      ov_latched_out <= 1'b0;
    else if (ov_trip)
      ov_latched_out <= 1'b1;
    else if (latch_reset_in)
      ov_latched_out <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Peak limit compensation
  // ----------------------------------------------------------------
  // Sampled once per primary stroke so the limit is stable while compared
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      overcurrent_limit_out <= `LIMIT_RESET;
    else if ((state_r == ST_ON) && (on_cnt_r == 32'h0))
      overcurrent_limit_out <= overpower_compensation_in;
  end

endmodule // flyback_protection_logic

`default_nettype wire

// ==== test/flyback_far_side.sv ====
`timescale 1ns/1ns
`default_nettype none
module flyback_far_side (
  input  wire logic       clk_in,
  input  wire logic       gate_in,
  input  wire logic       ov_in,
  input  wire logic [7:0] trip_at_in,
  output var  logic       stroke_out,
  output var  logic       aux_out,
  output var  logic       sense_out
);
  logic [7:0] on_r = 8'h00;
  logic [2:0] demag_r = 3'h0;
  logic       ring_r = 1'b0;
  always @(posedge clk_in)
  begin
    on_r <= gate_in ? on_r + 8'h01 : 8'h00;
    demag_r <= gate_in ? 3'h4 : demag_r - {2'h0, demag_r != 3'h0};
    ring_r <= !ring_r;
  end
  // Off the stroke the winding rings, so the comparator chatters
  always_comb
  begin
    sense_out = gate_in && trip_at_in != 8'h00 && on_r >= trip_at_in;
    stroke_out = !gate_in && demag_r != 3'h0;
    aux_out = stroke_out ? ov_in : ring_r;
  end
endmodule // flyback_far_side
`default_nettype wire

// ==== test/fpl_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module fpl_monitor #(parameter integer MAX_ON_CYCLES = 50) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic cycle_start_in,
  input wire logic primary_current_sense_in,
  input wire logic latch_reset_in,
  input wire logic flyback_gate_drive_out,
  input wire logic ov_latched_out,
  input wire logic safe_restart_out
);
  wire         g = flyback_gate_drive_out;
  logic [15:0] on_r;
  always_ff @(posedge clk_in or negedge resetn_in)
    if (!resetn_in)
      on_r <= 16'h0000;
    else
      on_r <= g ? on_r + 16'h0001 : 16'h0000;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_blank; g [*5]; endsequence
  a_gate_start: assert property ($rose(g) |-> $past(cycle_start_in))
    else $error("gate rose unasked");
  a_blank_hold: assert property ($rose(g) && !ov_latched_out |-> s_blank)
    else $error("gate cut in blanking");
  a_sense_end: assert property (g && primary_current_sense_in && on_r >= 16'h0005 |=> !g)
    else $error("sense ignored");
  a_on_limit: assert property (g |-> on_r <= MAX_ON_CYCLES)
    else $error("on time too long");
  a_restart_off: assert property (safe_restart_out |-> !g)
    else $error("gate in restart");
  a_latch_hold: assert property (ov_latched_out && !latch_reset_in |=> ov_latched_out)
    else $error("latch lost");
  a_latch_off: assert property (ov_latched_out && $past(ov_latched_out) |-> !g)
    else $error("gate while latched");
  a_no_retrigger: assert property ($fell(g) && !cycle_start_in |=> !g)
    else $error("gate retriggered");
endmodule // fpl_monitor
bind flyback_protection_logic fpl_monitor #(.MAX_ON_CYCLES(MAX_ON_CYCLES)) u_mon (
  .clk_in, .resetn_in, .cycle_start_in, .primary_current_sense_in, .latch_reset_in,
  .flyback_gate_drive_out, .ov_latched_out, .safe_restart_out);
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk_in = 1'b0, resetn_in = 1'b0, start = 1'b0, ovm = 1'b0, lrst = 1'b0;
  logic [7:0]  trip_at = 8'h00, comp = 8'h00, on_len = 8'h00, lim;
  logic [31:0] lfsr = 32'h1bba;
  logic        stroke, aux, sense, gate, latched, restart;
  logic [15:0] exp_q[$];
  integer      fails = 0, n_checks = 0, i, k;
  flyback_protection_logic #(.MAX_ON_CYCLES(50), .LEB_CYCLES(5), .RESTART_CYCLES(20)) DUT (
    .clk_in, .resetn_in, .cycle_start_in(start), .secondary_stroke_in(stroke),
    .aux_winding_sense_in(aux), .primary_current_sense_in(sense), .latch_reset_in(lrst),
    .overpower_compensation_in(comp), .flyback_gate_drive_out(gate),
    .overcurrent_limit_out(lim), .ov_latched_out(latched), .safe_restart_out(restart));
  flyback_far_side far (.clk_in, .gate_in(gate), .ov_in(ovm), .trip_at_in(trip_at),
    .stroke_out(stroke), .aux_out(aux), .sense_out(sense));
  initial forever #5 clk_in = ~clk_in;
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic test_done;
    check("pending", 16'h0000, 16'(exp_q.size()));
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Each gate fall yields one result: on length and limit
  always @(negedge clk_in)
    if (gate)
      on_len++;
    else if (on_len != 8'h00)
    begin
      check("on_len_limit", exp_q.size() ? exp_q.pop_front() : 'x, {on_len, lim});
      on_len = 8'h00;
    end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // A zero length means the start must be ignored
  task automatic go(input logic ov, input logic [7:0] d, input logic [7:0] len);
    lfsr = lfsr_next(lfsr);
    {comp, ovm, trip_at, start} = {lfsr[7:0], ov, d, 1'b1};
    if (len != 8'h00)
      exp_q.push_back({len, lfsr[7:0]});
    @(negedge clk_in);
    start = 1'b0;
    for (k = 0; k < 99 && gate; k++)
      @(negedge clk_in);
    if (gate)
    begin
      check("gate_fall", 16'h0000, {15'h0000, gate});
      test_done;
    end
    else
      repeat (6) @(negedge clk_in);
  endtask
  initial
  begin
    repeat (20) @(negedge clk_in);
    resetn_in = 1'b1;
    check("limit", 16'h00ff, {8'h00, lim});
    for (i = 1; i < 12; i++)
      go(1'b0, i[7:0], (i < 5 ? 8'h05 : i[7:0]) + 8'h01);
    go(1'b0, 8'h00, 8'h33);
    check("restart", 16'h0001, {15'h0000, restart});
    repeat (25) @(negedge clk_in);
    for (i = 0; i < 30; i++)
      go(i % 3 != 2, 8'h06, 8'h07);
    for (i = 0; i < 8; i++)
      go(1'b1, 8'h06, 8'h07);
    check("latch", 16'h0000, {15'h0000, latched});
    for (i = 0; i < 3; i++)
      go(1'b0, 8'h06, 8'h00);
    check("latch", 16'h0001, {15'h0000, latched});
    lrst = 1'b1;
    @(negedge clk_in);
    lrst = 1'b0;
    @(negedge clk_in);
    check("latch", 16'h0000, {15'h0000, latched});
    go(1'b0, 8'h06, 8'h07);
    resetn_in = 1'b0;
    @(negedge clk_in);
    resetn_in = 1'b1;
    go(1'b0, 8'h09, 8'h0a);
    test_done;
  end
endmodule // tb
`default_nettype wire
